// File: hdl/dds_waveform_control.v
// Serial-programmed direct digital synthesis core with waveform selection.
`timescale 1ns/1ps
`include "dds_waveform_map.vh"

// Function
// - Add offset zero or one, per phase offset select, to accumulator output.
// - Reset bit holds internal registers at zero, output at midscale.
// - Clock halt stops accumulation and freezes the output.
// - Converter power-down bit powers down the converter.
// - Square enable disconnects converter; pin shows data MSB or MSB halved.
// - Square disabled connects converter; mode bit picks sine or triangle.
// - Full-rate bit passes MSB straight; cleared, MSB is divided by two.
// - Mode bit one bypasses sine table, giving a triangle.
// - Mode bit zero sends phase through sine table.
// - Two 28-bit tuning words; select bit picks the active one.
// - Two 12-bit phase offsets; selected one is added to phase.
// - Output frequency is clock times tuning word over two to 28.
// - Offset shifts output by offset times one cycle over 4096.
// - Word with top bits 00 loads the fourteen control bits.
// - Top bits 01 load tuning word zero, 10 tuning word one.
// - Top bits 11 load a phase offset; bit 13 picks which.
// - Full-word mode: low half then high half, register updates after second.
module dds_waveform_control (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 rstn,
  // Three-wire serial write port
  input  wire                 serialSelectN,
  input  wire                 serialClk,
  input  wire                 serialData,
  // Converter and output pin
  output reg  [`DAC_BITS-1:0] dacCode_q,
  output wire                 converterPowerDown,
  output wire                 squareOutputEnable,
  output reg                  waveformOutputPin_q
);

  reg  [13:0]               control_q;
  reg  [1:0]                tuneLoadLow;
  reg  [1:0]                tuneLoadHigh;
  reg  [1:0]                tuneLoadFull;
  reg  [1:0]                phaseLoad;
  reg  [`ACC_BITS-1:0]      phaseAcc_q;
  reg  [14:0]               shift_q;
  reg  [3:0]                bitCount_q;
  reg                       serialClkPrev_q;
  reg  [`PAYLOAD_BITS-1:0]  pendingLow_q;
  reg                       pendingValid_q;
  reg                       pendingIdx_q;
  reg                       msbPrev_q;
  reg                       halfRate_q;

  wire                      sampleEdge;
  wire                      wordDone;
  wire [`WORD_BITS-1:0]     word;
  wire [1:0]                addr;
  wire [`PAYLOAD_BITS-1:0]  payload;
  wire                      tuneIdx;
  wire [`ACC_BITS-1:0]      selTuningWord;
  wire [`OFFSET_BITS-1:0]   selPhaseOffset;
  wire [`OFFSET_BITS-1:0]   phaseSum;
  wire [`DAC_BITS-1:0]      sineCode;
  wire [`DAC_BITS-1:0]      triangleCode;
  wire [`DAC_BITS-1:0]      nextCode;
  wire                      dataMsb;
  wire                      running;
  wire [2*`ACC_BITS-1:0]    tuningWords;
  wire [2*`OFFSET_BITS-1:0] phaseOffsets;
  genvar                    entry;

  // Data is taken on each falling serial clock edge while selected.
  assign sampleEdge = serialClkPrev_q & ~serialClk & ~serialSelectN;
  assign wordDone   = sampleEdge & (bitCount_q == 4'hF);
  assign word       = {shift_q, serialData};
  assign addr       = word[`ADDR_HI:`ADDR_LO];
  assign payload    = word[`PAYLOAD_BITS-1:0];
  assign tuneIdx    = addr[1];

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serialClkPrev_q <= 1'b1;
      shift_q         <= 15'h0000;
      bitCount_q      <= 4'h0;
    end else begin
      serialClkPrev_q <= serialClk;
      if (serialSelectN) begin
        bitCount_q <= 4'h0;
      end else if (sampleEdge) begin
        shift_q    <= word[14:0];
        bitCount_q <= bitCount_q + 4'h1;
      end
    end
  end

  // Control word and the pending low half of a full-word tuning load.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      control_q      <= `CTRL_RESET_VAL;
      pendingLow_q   <= 14'h0000;
      pendingValid_q <= 1'b0;
      pendingIdx_q   <= 1'b0;
    end else if (wordDone) begin
      if (addr == `ADDR_CONTROL) begin
        control_q      <= payload;
        pendingValid_q <= 1'b0;
      end else if ((addr != `ADDR_PHASE) && control_q[`CTRL_FULL_WORD]) begin
        if (pendingValid_q && (pendingIdx_q == tuneIdx)) begin
          pendingValid_q <= 1'b0;
        end else begin
          pendingLow_q   <= payload;
          pendingIdx_q   <= tuneIdx;
          pendingValid_q <= 1'b1;
        end
      end
    end
  end

  // Per-slot write strobes decoded from a completed serial word.
  always @* begin
    tuneLoadLow  = 2'h0;
    tuneLoadHigh = 2'h0;
    tuneLoadFull = 2'h0;
    phaseLoad    = 2'h0;
    if (wordDone && (addr == `ADDR_PHASE)) begin
      phaseLoad[word[`PHASE_SEL_BIT]] = 1'b1;
    end else if (wordDone && (addr != `ADDR_CONTROL)) begin
      if (control_q[`CTRL_FULL_WORD]) begin
        tuneLoadFull[tuneIdx] = pendingValid_q
                                & (pendingIdx_q == tuneIdx);
      end else if (control_q[`CTRL_UPPER_HALF]) begin
        tuneLoadHigh[tuneIdx] = 1'b1;
      end else begin
        tuneLoadLow[tuneIdx] = 1'b1;
      end
    end
  end

  // One storage slot per tuning word and per phase offset.
  generate
    for (entry = 0; entry < 2; entry = entry + 1) begin : slot
      reg [`ACC_BITS-1:0]    tuneWord_q;
      reg [`OFFSET_BITS-1:0] offset_q;

      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          tuneWord_q <= 28'h0000000;
          offset_q   <= 12'h000;
        end else begin
          if (tuneLoadFull[entry]) begin
            // The word changes in one step, never half loaded.
            tuneWord_q <= {payload, pendingLow_q};
          end else if (tuneLoadHigh[entry]) begin
            tuneWord_q[27:14] <= payload;
          end else if (tuneLoadLow[entry]) begin
            tuneWord_q[13:0] <= payload;
          end
          if (phaseLoad[entry]) begin
            offset_q <= word[`OFFSET_BITS-1:0];
          end
        end
      end

      assign tuningWords[entry*`ACC_BITS +: `ACC_BITS]          = tuneWord_q;
      assign phaseOffsets[entry*`OFFSET_BITS +: `OFFSET_BITS] = offset_q;
    end
  endgenerate

  assign selTuningWord  = control_q[`CTRL_TUNE_SEL]
                          ? tuningWords[2*`ACC_BITS-1:`ACC_BITS]
                          : tuningWords[`ACC_BITS-1:0];
  assign selPhaseOffset = control_q[`CTRL_PHASE_SEL]
                          ? phaseOffsets[2*`OFFSET_BITS-1:`OFFSET_BITS]
                          : phaseOffsets[`OFFSET_BITS-1:0];
  // Offset is in 1/4096-cycle steps on the top phase bits.
  assign phaseSum = phaseAcc_q[27:16] + selPhaseOffset;
  assign running  = ~control_q[`CTRL_CLOCK_HALT];

  sine_lookup_table sineTable (
    .phase     (phaseSum[11:5]),
    .amplitude (sineCode)
  );

  assign triangleCode = phaseSum[11] ? ~phaseSum[10:1] : phaseSum[10:1];
  assign nextCode = control_q[`CTRL_TRIANGLE] ? triangleCode
                                              : sineCode;
  assign dataMsb  = dacCode_q[`DAC_BITS-1];

  assign converterPowerDown = control_q[`CTRL_DAC_PD];
  assign squareOutputEnable = control_q[`CTRL_SQUARE_EN];

  // Phase accumulator and converter data path.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phaseAcc_q <= 28'h0000000;
      dacCode_q  <= `DAC_MIDSCALE;
      msbPrev_q  <= 1'b0;
      halfRate_q <= 1'b0;
    end else if (control_q[`CTRL_RESET]) begin
      phaseAcc_q <= 28'h0000000;
      dacCode_q  <= `DAC_MIDSCALE;
      msbPrev_q  <= 1'b0;
      halfRate_q <= 1'b0;
    end else if (running) begin
      phaseAcc_q <= phaseAcc_q + selTuningWord;
      dacCode_q  <= nextCode;
      msbPrev_q  <= dataMsb;
      if (dataMsb && !msbPrev_q) begin
        halfRate_q <= ~halfRate_q;
      end
    end
  end

  // Square pin follows the data MSB or its halved copy.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waveformOutputPin_q <= 1'b0;
    end else if (!control_q[`CTRL_SQUARE_EN]) begin
      waveformOutputPin_q <= 1'b0;
    end else if (control_q[`CTRL_FULL_RATE]) begin
      waveformOutputPin_q <= dataMsb;
    end else begin
      waveformOutputPin_q <= halfRate_q;
    end
  end

endmodule // dds_waveform_control

// File: hdl/dds_waveform_map.vh
// Field positions, serial address codes and constants of the synthesis core.
`ifndef DDS_WAVEFORM_MAP_VH
`define DDS_WAVEFORM_MAP_VH

`define WORD_BITS        16
`define ADDR_HI          15
`define ADDR_LO          14
`define ADDR_CONTROL     2'h0
`define ADDR_TUNE_ZERO   2'h1
`define ADDR_TUNE_ONE    2'h2
`define ADDR_PHASE       2'h3
`define PAYLOAD_BITS     14
`define PHASE_SEL_BIT    13

`define CTRL_FULL_WORD   13
`define CTRL_UPPER_HALF  12
`define CTRL_TUNE_SEL    11
`define CTRL_PHASE_SEL   10
`define CTRL_RESET       8
`define CTRL_CLOCK_HALT  7
`define CTRL_DAC_PD      6
`define CTRL_SQUARE_EN   5
`define CTRL_FULL_RATE   3
`define CTRL_TRIANGLE    1
`define CTRL_RESET_VAL   14'h0000

`define ACC_BITS         28
`define OFFSET_BITS      12
`define DAC_BITS         10
`define DAC_MIDSCALE     10'h200

`endif

// File: hdl/sine_lookup_table.v
// Quarter-wave sine table turning a phase into a 10-bit offset-binary code.
`timescale 1ns/1ps

module sine_lookup_table (
  // Phase in
  input  wire [6:0] phase,
  // Amplitude out
  output reg  [9:0] amplitude
);

  reg [4:0] index;
  reg [8:0] magnitude;

  always @* begin
    index = phase[5] ? ~phase[4:0] : phase[4:0];
    case (index)
      5'h00: magnitude = 9'h00D;
      5'h01: magnitude = 9'h026;
      5'h02: magnitude = 9'h03F;
      5'h03: magnitude = 9'h057;
      5'h04: magnitude = 9'h070;
      5'h05: magnitude = 9'h088;
      5'h06: magnitude = 9'h0A0;
      5'h07: magnitude = 9'h0B8;
      5'h08: magnitude = 9'h0CF;
      5'h09: magnitude = 9'h0E6;
      5'h0A: magnitude = 9'h0FC;
      5'h0B: magnitude = 9'h111;
      5'h0C: magnitude = 9'h126;
      5'h0D: magnitude = 9'h13A;
      5'h0E: magnitude = 9'h14E;
      5'h0F: magnitude = 9'h160;
      5'h10: magnitude = 9'h172;
      5'h11: magnitude = 9'h183;
      5'h12: magnitude = 9'h193;
      5'h13: magnitude = 9'h1A2;
      5'h14: magnitude = 9'h1B0;
      5'h15: magnitude = 9'h1BD;
      5'h16: magnitude = 9'h1C8;
      5'h17: magnitude = 9'h1D3;
      5'h18: magnitude = 9'h1DD;
      5'h19: magnitude = 9'h1E5;
      5'h1A: magnitude = 9'h1EC;
      5'h1B: magnitude = 9'h1F3;
      5'h1C: magnitude = 9'h1F7;
      5'h1D: magnitude = 9'h1FB;
      5'h1E: magnitude = 9'h1FE;
      default: magnitude = 9'h1FF;
    endcase
    // The upper half of the cycle mirrors the lower half below midscale.
    if (phase[6]) begin
      amplitude = 10'h1FF - {1'b0, magnitude};
    end else begin
      amplitude = 10'h200 + {1'b0, magnitude};
    end
  end

endmodule // sine_lookup_table

// File: test/dds_waveform_control_sva.sv
// Assertions on the pins of the synthesis core.
`timescale 1ns/1ps
module dds_waveform_control_sva (
  // Watched ports
  input wire       clk_sys,
  input wire       rstn,
  input wire       serialSelectN,
  input wire       serialClk,
  input wire       serialData,
  input wire [9:0] dacCode_q,
  input wire       converterPowerDown,
  input wire       squareOutputEnable,
  input wire       waveformOutputPin_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Holds one edge after any serial bit was taken on a falling serial clock while selected.
  sequence wordDone;
    $past(!serialSelectN && !serialClk) && $past(serialClk, 2);
  endsequence
  a_reset_pins: assert property ($rose(rstn) |-> !converterPowerDown
    && !squareOutputEnable && !waveformOutputPin_q) else $error("reset pins");
  a_reset_mid: assert property ($rose(rstn) |->
    dacCode_q == 10'h200) else $error("not midscale");
  a_pd_word: assert property ($changed(converterPowerDown) |-> wordDone)
    else $error("powerdown moved");
  a_sq_rise: assert property ($rose(squareOutputEnable) |-> wordDone)
    else $error("square on");
  a_sq_fall: assert property ($fell(squareOutputEnable) |-> wordDone)
    else $error("square off");
  a_pin_idle: assert property (!squareOutputEnable ##1
    !squareOutputEnable |-> !waveformOutputPin_q) else $error("pin busy");
  a_pin_sq: assert property ($rose(waveformOutputPin_q) |->
    $past(squareOutputEnable)) else $error("pin rose");
  a_pin_msb: assert property (
    squareOutputEnable && $past(squareOutputEnable)
    && $past(serialSelectN, 2)
    && $changed(waveformOutputPin_q) |-> dacCode_q[9] != $past(dacCode_q[9])
    || $past(dacCode_q[9]) != $past(dacCode_q[9], 2)
    || $past(dacCode_q[9], 2) != $past(dacCode_q[9], 3))
    else $error("pin msb");
endmodule // dds_waveform_control_sva

bind dds_waveform_control dds_waveform_control_sva chk (
  .clk_sys(clk_sys), .rstn(rstn), .serialSelectN(serialSelectN),
  .serialClk(serialClk), .serialData(serialData), .dacCode_q(dacCode_q),
  .converterPowerDown(converterPowerDown),
  .squareOutputEnable(squareOutputEnable),
  .waveformOutputPin_q(waveformOutputPin_q));

// File: test/dds_host_model.sv
// Host model that writes words over the three-wire serial port.
`timescale 1ns/1ps
module dds_host_model (
  // Clock in, serial lines out
  input  wire clk_sys,
  output reg  serialSelectN = 1'b1,
  output reg  serialClk = 1'b1,
  output reg  serialData = 1'b1
);
  integer i;
  // Each serial clock level lasts two cycles; the path settles afterwards.
  task tx(input [15:0] w);
    begin
      @(negedge clk_sys);
      serialSelectN = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        serialData = w[i];
        repeat (2) @(negedge clk_sys);
        serialClk = 1'b0;
        repeat (2) @(negedge clk_sys);
        serialClk = 1'b1;
      end
      serialSelectN = 1'b1;
      serialData = ~serialData;
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule // dds_host_model

// File: test/tb.sv
// Bench for the synthesis core, driven through its serial port.
`timescale 1ns/1ps
module tb;
  reg        clk_sys = 1'b0;
  reg        rstn = 1'b0;
  wire       serialSelectN, serialClk, serialData;
  wire [9:0] dacCode_q;
  wire       converterPowerDown, squareOutputEnable, waveformOutputPin_q;
  integer    fails = 0;
  integer    samples_checked = 0;
  integer    rises, chg, prs, k;
  reg  [9:0] last;
  reg        lastPin;
  reg [15:0] script [0:15];
  integer    wordIdx = 0;

  always #20 clk_sys = ~clk_sys;

  dds_host_model host (.clk_sys(clk_sys), .serialSelectN(serialSelectN),
    .serialClk(serialClk), .serialData(serialData));
  dds_waveform_control DUT (.clk_sys(clk_sys), .rstn(rstn),
    .serialSelectN(serialSelectN), .serialClk(serialClk),
    .serialData(serialData), .dacCode_q(dacCode_q),
    .converterPowerDown(converterPowerDown),
    .squareOutputEnable(squareOutputEnable),
    .waveformOutputPin_q(waveformOutputPin_q));

  task check(input [31:0] seen, input [31:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("MISMATCH at %0t: saw %0h want %0h", $time, seen, want);
      end
    end
  endtask

  task meas(input integer n);
    begin
      rises = 0;
      chg = 0;
      prs = 0;
      for (k = 0; k < n; k = k + 1) begin
        last = dacCode_q;
        lastPin = waveformOutputPin_q;
        @(negedge clk_sys);
        rises = rises + (!last[9] && dacCode_q[9]);
        chg = chg + (last !== dacCode_q);
        prs = prs + (!lastPin && waveformOutputPin_q);
      end
    end
  endtask

  // Sends the next word of the script over the serial link.
  task send;
    begin
      host.tx(script[wordIdx]);
      wordIdx = wordIdx + 1;
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  initial begin
    #400000;
    fails = fails + 1;
    print_verdict;
  end

  // Every word keeps the reserved control bits at zero.
  // A low half of all ones makes an early full-word load visible at once.
  initial begin
    script[0]  = 16'hE400;
    script[1]  = 16'h0002;
    script[2]  = 16'h0402;
    script[3]  = 16'h0400;
    script[4]  = 16'h0040;
    script[5]  = 16'h0020;
    script[6]  = 16'h2002;
    script[7]  = 16'h7FFF;
    script[8]  = 16'h5000;
    script[9]  = 16'h2028;
    script[10] = 16'h2020;
    script[11] = 16'h1000;
    script[12] = 16'h8800;
    script[13] = 16'h1800;
    script[14] = 16'h1880;
    script[15] = 16'h1900;
    repeat (20) @(negedge clk_sys);
    check(dacCode_q, 10'h200);
    rstn = 1'b1;
    @(negedge clk_sys);
    send;
    send;
    check(dacCode_q, 10'h000);
    send;
    check(dacCode_q, 10'h200);
    send;
    check(dacCode_q > 10'h300, 1'b1);
    send;
    check(converterPowerDown, 1'b1);
    send;
    check({converterPowerDown, squareOutputEnable}, 2'h1);
    send;
    send;
    meas(40);
    check(chg, 0);
    send;
    meas(400);
    check(rises, 100);
    send;
    meas(400);
    check(prs, 100);
    send;
    meas(400);
    check(prs, 50);
    send;
    send;
    send;
    meas(400);
    check(rises, 50);
    send;
    meas(100);
    check(chg, 0);
    send;
    meas(50);
    check({dacCode_q, chg[3:0]}, 14'h2000);
    print_verdict;
  end
endmodule // tb
